/* hw/sdsc_pkg.sv */
// sdsc_pkg: register map, field positions and reset values of the
// sensor data path and sequencer configuration bank.
// assumes: registers are 8 bits wide and addressed by a 7-bit index.
package sdsc_pkg;

    localparam int unsigned SDSC_AW = 7;
    localparam int unsigned SDSC_NLANE = 3;

    // register offsets
    localparam logic [6:0] SDSC_A_RSVD_A = 7'h15;
    localparam logic [6:0] SDSC_A_RSVD_B = 7'h16;
    localparam logic [6:0] SDSC_A_DPCFG_A = 7'h17;
    localparam logic [6:0] SDSC_A_DPCFG_B = 7'h18;
    localparam logic [6:0] SDSC_A_RSVD_C = 7'h19;
    localparam logic [6:0] SDSC_A_DAC = 7'h1a;
    localparam logic [6:0] SDSC_A_RSVD_D = 7'h1b;
    localparam logic [6:0] SDSC_A_RSVD_E = 7'h1c;
    localparam logic [6:0] SDSC_A_RSVD_F = 7'h1d;
    localparam logic [6:0] SDSC_A_L0_CTL = 7'h1e;
    localparam logic [6:0] SDSC_A_L0_PAT = 7'h1f;
    localparam logic [6:0] SDSC_A_L1_CTL = 7'h20;
    localparam logic [6:0] SDSC_A_L1_PAT = 7'h21;
    localparam logic [6:0] SDSC_A_L12_CTL = 7'h36;
    localparam logic [6:0] SDSC_A_L12_PAT = 7'h37;
    localparam logic [6:0] SDSC_A_SEQ_A = 7'h38;
    localparam logic [6:0] SDSC_A_SEQ_B = 7'h39;
    localparam logic [6:0] SDSC_A_SEQ_C = 7'h3a;
    localparam logic [6:0] SDSC_A_SEQ_D = 7'h3b;

    // reset values
    localparam logic [7:0] SDSC_R_RSVD_A = 8'h20;
    localparam logic [7:0] SDSC_R_RSVD_B = 8'hc0;
    localparam logic [7:0] SDSC_R_DPCFG_A = 8'hc0;
    localparam logic [7:0] SDSC_R_DPCFG_B = 8'h2a;
    localparam logic [7:0] SDSC_R_ZERO = 8'h00;
    localparam logic [7:0] SDSC_R_DAC = 8'h80;
    localparam logic [7:0] SDSC_R_RSVD_D = 8'h80;
    localparam logic [7:0] SDSC_R_SEQ_A = 8'h02;
    localparam logic [7:0] SDSC_R_SEQ_B = 8'h10;
    localparam logic [7:0] SDSC_R_SEQ_C = 8'h09;
    localparam logic [7:0] SDSC_DAC_DEFAULT = 8'h80;

    // field positions
    localparam int unsigned SDSC_B_DAC_UPLOAD = 2;
    localparam int unsigned SDSC_B_PRBS = 3;
    localparam int unsigned SDSC_B_TRAIN_LO = 6;
    localparam int unsigned SDSC_B_BYPASS = 0;
    localparam int unsigned SDSC_B_FPN = 1;
    localparam int unsigned SDSC_B_TESTPAT = 2;
    localparam int unsigned SDSC_B_PAT_LO = 4;
    localparam int unsigned SDSC_B_CAPTURE = 0;
    localparam int unsigned SDSC_B_MASTER = 1;
    localparam int unsigned SDSC_B_TRIGGERED = 2;
    localparam int unsigned SDSC_B_SUBSAMPLE = 3;
    localparam int unsigned SDSC_B_COLOR = 4;
    localparam int unsigned SDSC_B_DUAL = 5;
    localparam int unsigned SDSC_B_TRIPLE = 6;
    localparam int unsigned SDSC_B_ROWSEL = 7;
    localparam int unsigned SDSC_B_WIN_LO = 5;
    localparam int unsigned SDSC_B_CRC = 0;
    localparam int unsigned SDSC_B_FPNCAL = 2;
    localparam int unsigned SDSC_B_NDR_LO = 3;
    localparam int unsigned SDSC_B_CLKGRAN = 6;
    localparam int unsigned SDSC_B_DEFER = 7;

    // skip sequences, lsb first
    localparam logic [7:0] SDSC_SKIP_COLOR = 8'h33;
    localparam logic [4:0] SDSC_SKIP_MONO = 5'h15;
    localparam logic [2:0] SDSC_SKIP_MONO_LAST = 3'h4;

    // divider for the internal sequencer clock
    localparam logic [3:0] SDSC_DIV = 4'h a;
    localparam logic [3:0] SDSC_DIV_LAST = 4'h9;
    localparam logic [15:0] SDSC_LINE_TICKS = 16'h0010;
    localparam logic [7:0] SDSC_PRBS_SEED = 8'hff;

    typedef enum logic [3:0] {
        SDSC_IDLE = 4'b0001,
        SDSC_INTEG = 4'b0010,
        SDSC_READ = 4'b0100,
        SDSC_OVHD = 4'b1000
    } sdsc_state_t;

endpackage

/* hw/sdsc_lane.sv */
// sdsc_lane: one data lane selector: bypass, fpn correction, test
// pattern or prbs in place of pixel data.
// assumes: caller registers the result; all inputs share clk.
`timescale 1ns/100ps
module sdsc_lane
(
    input wire logic [7:0] ctl,
    input wire logic [7:0] pat,
    input wire logic [9:0] adc,
    input wire logic [9:0] fpn_off,
    input wire logic [9:0] prbs,
    input wire logic prbs_en,
    output logic [9:0] pix
);
    import sdsc_pkg::*;

    // ============================================================
    // data select
    wire [9:0] test_word = {ctl[SDSC_B_PAT_LO +: 2], pat};
    wire [9:0] src = ctl[SDSC_B_TESTPAT] ? test_word : adc;
    wire [9:0] corr = ctl[SDSC_B_FPN] ? src - fpn_off : src;
    wire [9:0] proc_w = prbs_en ? prbs : corr;
    assign pix = ctl[SDSC_B_BYPASS] ? adc : proc_w;

endmodule // sdsc_lane

/* hw/sdsc_top.sv */
// sdsc_top: configuration bank and small readout sequencer of the
// sensor data path.
// assumes: register port strobes are synchronous to clk, one cycle wide.
`timescale 1ns/100ps
module sdsc_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [sdsc_pkg::SDSC_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [29:0] adc_data,
    input wire logic trigger,
    input wire logic external_integration_timing_1,
    input wire logic external_integration_timing_2,
    input wire logic external_integration_timing_3,
    output logic [29:0] lane_data,
    output logic [9:0] train_word,
    output logic [7:0] dac_offset,
    output logic seq_tick,
    output logic pixel_reset,
    output logic row_select,
    output logic row_overhead_interval,
    output logic row_skip,
    output logic [1:0] window_count,
    output logic crc_en,
    output logic fpn_cal,
    output logic [2:0] ndr_steps,
    output logic ndr_invalid,
    output logic slope_reset,
    output logic [2:0] seq_state
);
    import sdsc_pkg::*;

    // ============================================================
    // register storage
    logic [7:0] cfg_a_q, cfg_b_q, dac_q, mode_a_q, mode_b_q, mode_c_q, mode_d_q;
    logic [7:0] rsv_a_q, rsv_b_q, rsv_c_q, rsv_d_q, rsv_e_q, rsv_f_q;
    logic [7:0] ctl_q [SDSC_NLANE];
    logic [7:0] pat_q [SDSC_NLANE];
    logic [6:0] ctl_addr [SDSC_NLANE];
    assign ctl_addr[0] = SDSC_A_L0_CTL;
    assign ctl_addr[1] = SDSC_A_L1_CTL;
    assign ctl_addr[2] = SDSC_A_L12_CTL;

    wire wr_cfg_a = reg_wr && (reg_addr == SDSC_A_DPCFG_A);
    wire wr_cfg_b = reg_wr && (reg_addr == SDSC_A_DPCFG_B);
    wire wr_dac = reg_wr && (reg_addr == SDSC_A_DAC);
    wire wr_mode_a = reg_wr && (reg_addr == SDSC_A_SEQ_A);
    wire wr_mode_b = reg_wr && (reg_addr == SDSC_A_SEQ_B);
    wire wr_mode_c = reg_wr && (reg_addr == SDSC_A_SEQ_C);
    wire wr_mode_d = reg_wr && (reg_addr == SDSC_A_SEQ_D);
    wire wr_rsv = reg_wr && (reg_addr >= SDSC_A_RSVD_A) && (reg_addr <= SDSC_A_RSVD_F);

    // global configuration registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_a_q <= SDSC_R_DPCFG_A;
            cfg_b_q <= SDSC_R_DPCFG_B;
            dac_q <= SDSC_R_DAC;
            mode_a_q <= SDSC_R_SEQ_A;
            mode_b_q <= SDSC_R_SEQ_B;
            mode_c_q <= SDSC_R_SEQ_C;
            mode_d_q <= SDSC_R_ZERO;
        end
        else
        begin
            if (wr_cfg_a) cfg_a_q <= reg_wdata;
            if (wr_cfg_b) cfg_b_q <= reg_wdata;
            if (wr_dac) dac_q <= reg_wdata;
            if (wr_mode_a) mode_a_q <= reg_wdata;
            if (wr_mode_b) mode_b_q <= reg_wdata;
            if (wr_mode_c) mode_c_q <= reg_wdata;
            if (wr_mode_d) mode_d_q <= reg_wdata;
        end
    end

    // reserved registers keep whatever is written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsv_a_q <= SDSC_R_RSVD_A;
            rsv_b_q <= SDSC_R_RSVD_B;
            rsv_c_q <= SDSC_R_ZERO;
            rsv_d_q <= SDSC_R_RSVD_D;
            rsv_e_q <= SDSC_R_ZERO;
            rsv_f_q <= SDSC_R_ZERO;
        end
        else if (wr_rsv)
        begin
            case (reg_addr)
                SDSC_A_RSVD_A: rsv_a_q <= reg_wdata;
                SDSC_A_RSVD_B: rsv_b_q <= reg_wdata;
                SDSC_A_RSVD_C: rsv_c_q <= reg_wdata;
                SDSC_A_RSVD_D: rsv_d_q <= reg_wdata;
                SDSC_A_RSVD_E: rsv_e_q <= reg_wdata;
                SDSC_A_RSVD_F: rsv_f_q <= reg_wdata;
                default: rsv_a_q <= rsv_a_q;
            endcase
        end
    end

    // ============================================================
    // per-lane registers and data path
    logic [9:0] prbs_q;
    logic [29:0] lane_d;
    logic [9:0] fpn_q;
    genvar gi;
    generate
        for (gi = 0; gi < SDSC_NLANE; gi++)
        begin : g_lane
            wire wr_ctl = reg_wr && (reg_addr == ctl_addr[gi]);
            wire wr_pat = reg_wr && (reg_addr == ctl_addr[gi] + 7'h01);
            // lane control and test pattern, both reset to zero
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ctl_q[gi] <= SDSC_R_ZERO;
                    pat_q[gi] <= SDSC_R_ZERO;
                end
                else
                begin
                    if (wr_ctl) ctl_q[gi] <= reg_wdata;
                    if (wr_pat) pat_q[gi] <= reg_wdata;
                end
            end
            sdsc_lane u_lane
            (
                .ctl(ctl_q[gi]),
                .pat(pat_q[gi]),
                .adc(adc_data[gi*10 +: 10]),
                .fpn_off(fpn_q),
                .prbs(prbs_q),
                .prbs_en(cfg_a_q[SDSC_B_PRBS]),
                .pix(lane_d[gi*10 +: 10])
            );
        end
    endgenerate

    // ============================================================
    // register read mux
    logic [7:0] rd_d;
    always_comb
    begin
        rd_d = SDSC_R_ZERO;
        case (reg_addr)
            SDSC_A_RSVD_A: rd_d = rsv_a_q;
            SDSC_A_RSVD_B: rd_d = rsv_b_q;
            SDSC_A_DPCFG_A: rd_d = cfg_a_q;
            SDSC_A_DPCFG_B: rd_d = cfg_b_q;
            SDSC_A_RSVD_C: rd_d = rsv_c_q;
            SDSC_A_DAC: rd_d = dac_q;
            SDSC_A_RSVD_D: rd_d = rsv_d_q;
            SDSC_A_RSVD_E: rd_d = rsv_e_q;
            SDSC_A_RSVD_F: rd_d = rsv_f_q;
            SDSC_A_L0_CTL: rd_d = ctl_q[0];
            SDSC_A_L0_PAT: rd_d = pat_q[0];
            SDSC_A_L1_CTL: rd_d = ctl_q[1];
            SDSC_A_L1_PAT: rd_d = pat_q[1];
            SDSC_A_L12_CTL: rd_d = ctl_q[2];
            SDSC_A_L12_PAT: rd_d = pat_q[2];
            SDSC_A_SEQ_A: rd_d = mode_a_q;
            SDSC_A_SEQ_B: rd_d = mode_b_q;
            SDSC_A_SEQ_C: rd_d = mode_c_q;
            SDSC_A_SEQ_D: rd_d = mode_d_q;
            default: rd_d = SDSC_R_ZERO;
        endcase
    end

    // ============================================================
    // divide by ten tick for the sequencer
    logic [3:0] div_q;
    wire tick = (div_q == SDSC_DIV_LAST);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) div_q <= 4'h0;
        else div_q <= tick ? 4'h0 : div_q + 4'h1;
    end

    // prbs (x^10 + x^7 + 1) and fpn calibration offset, sequencer rate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prbs_q <= {2'b11, SDSC_PRBS_SEED};
            fpn_q <= 10'h000;
        end
        else if (tick)
        begin
            prbs_q <= {prbs_q[8:0], prbs_q[9] ^ prbs_q[6]};
            if (mode_c_q[SDSC_B_FPNCAL] && row_overhead_interval)
                fpn_q <= adc_data[9:0];
        end
    end

    // ============================================================
    // timer length in sequencer ticks: fixed SDSC_LINE_TICKS, or 2**exponent with clock granularity
    wire gran_clk = mode_c_q[SDSC_B_CLKGRAN];
    wire [15:0] timer_len = gran_clk ? (16'h0001 << mode_d_q[3:0])
                                     : SDSC_LINE_TICKS;
    wire master = mode_a_q[SDSC_B_MASTER];
    wire ext_int = external_integration_timing_1 | external_integration_timing_2
                   | external_integration_timing_3;
    wire [2:0] ndr_d = mode_c_q[SDSC_B_NDR_LO +: 3];

    sdsc_state_t st_q, st_d;
    logic [15:0] cnt_q;
    logic [2:0] samp_q;
    logic [2:0] skip_q;
    logic trig_pend_q;
    wire cnt_done = (cnt_q == 16'h0000);
    // deferral: triggers outside overhead wait for it when bit 7 set
    wire trig_ok = trig_pend_q && (!mode_c_q[SDSC_B_DEFER] || st_q == SDSC_OVHD);
    wire start_int = mode_a_q[SDSC_B_TRIGGERED] ? trig_ok : 1'b1;
    wire int_done = master ? cnt_done : !ext_int;

    // state sequencing
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            SDSC_IDLE: if (mode_a_q[SDSC_B_CAPTURE] && start_int) st_d = SDSC_INTEG;
            SDSC_INTEG: if (int_done) st_d = SDSC_READ;
            SDSC_READ: if (cnt_done) st_d = SDSC_OVHD;
            SDSC_OVHD: st_d = mode_a_q[SDSC_B_CAPTURE] ? SDSC_READ : SDSC_IDLE;
            default: st_d = SDSC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= SDSC_IDLE;
            cnt_q <= 16'h0000;
            samp_q <= 3'h0;
            skip_q <= 3'h0;
            trig_pend_q <= 1'b0;
        end
        else
        begin
            if (trigger) trig_pend_q <= 1'b1; // set wins over clear
            else if (tick && st_q == SDSC_IDLE && st_d == SDSC_INTEG) trig_pend_q <= 1'b0;
            if (tick)
            begin
                st_q <= st_d;
                cnt_q <= (st_d != st_q) ? timer_len : (cnt_done ? cnt_q : cnt_q - 16'h0001);
                if (st_d == SDSC_OVHD && st_q == SDSC_READ)
                begin
                    samp_q <= (samp_q + 3'h1 >= ndr_d) ? 3'h0 : samp_q + 3'h1;
                    skip_q <= (!mode_a_q[SDSC_B_COLOR] && skip_q >= SDSC_SKIP_MONO_LAST)
                              ? 3'h0 : skip_q + 3'h1;
                end
            end
        end
    end

    wire skip_bit = mode_a_q[SDSC_B_COLOR] ? SDSC_SKIP_COLOR[skip_q]
                : SDSC_SKIP_MONO[(skip_q > SDSC_SKIP_MONO_LAST) ? SDSC_SKIP_MONO_LAST : skip_q];
    wire slope_d = (st_q == SDSC_INTEG) && (mode_a_q[SDSC_B_DUAL] || mode_a_q[SDSC_B_TRIPLE])
                   && (cnt_q == (timer_len >> 1) || (mode_a_q[SDSC_B_TRIPLE]
                   && cnt_q == (timer_len >> 2)));
    wire rowsel_d = (st_q == SDSC_OVHD) || ((st_q == SDSC_READ)
                    && (mode_a_q[SDSC_B_ROWSEL] || cnt_q == timer_len));
    // ndr: pixel reset only on the first sample of a series
    wire preset_d = (st_q == SDSC_INTEG) && (samp_q == 3'h0);

    // ============================================================
    // registered outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            lane_data <= 30'h0000_0000;
            train_word <= 10'h000;
            dac_offset <= SDSC_DAC_DEFAULT;
            seq_tick <= 1'b0;
            pixel_reset <= 1'b0;
            row_select <= 1'b0;
            row_overhead_interval <= 1'b0;
            row_skip <= 1'b0;
            window_count <= 2'h0;
            crc_en <= 1'b0;
            fpn_cal <= 1'b0;
            ndr_steps <= 3'h0;
            ndr_invalid <= 1'b0;
            slope_reset <= 1'b0;
            seq_state <= 3'h0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_d : reg_rdata;
            lane_data <= lane_d;
            train_word <= {cfg_a_q[SDSC_B_TRAIN_LO +: 2], cfg_b_q};
            dac_offset <= cfg_a_q[SDSC_B_DAC_UPLOAD] ? dac_q : SDSC_DAC_DEFAULT;
            seq_tick <= tick;
            pixel_reset <= preset_d;
            row_select <= rowsel_d;
            row_overhead_interval <= (st_q == SDSC_OVHD);
            row_skip <= mode_a_q[SDSC_B_SUBSAMPLE] && !skip_bit;
            window_count <= mode_b_q[SDSC_B_WIN_LO +: 2];
            crc_en <= mode_c_q[SDSC_B_CRC];
            fpn_cal <= mode_c_q[SDSC_B_FPNCAL];
            ndr_steps <= ndr_d;
            ndr_invalid <= (ndr_d == 3'h0);
            slope_reset <= slope_d;
            seq_state <= st_q[3:1];
        end
    end

    // ============================================================
    // checks
    AST_DAC_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg_a_q[SDSC_B_DAC_UPLOAD] |=> dac_offset == SDSC_DAC_DEFAULT)
        else $error("dac offset not default");
    AST_TRAIN: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> train_word == {$past(cfg_a_q[7:6]), $past(cfg_b_q)})
        else $error("training word mismatch");
    AST_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_q[0][SDSC_B_BYPASS] |=> lane_data[9:0] == $past(adc_data[9:0]))
        else $error("bypass not transparent");
    AST_TESTPAT: assert property (@(posedge clk) disable iff (!rst_n)
        (ctl_q[1][2:0] == 3'h4 && !cfg_a_q[SDSC_B_PRBS])
        |=> lane_data[19:10] == {$past(ctl_q[1][5:4]), $past(pat_q[1])})
        else $error("test pattern not inserted");
    AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == SDSC_IDLE && !mode_a_q[SDSC_B_CAPTURE]) |=> st_q == SDSC_IDLE)
        else $error("capture started while disabled");
    AST_DIV: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick [*8] ##1 !tick ##1 tick)
        else $error("sequencer tick not divide by ten");
    AST_WIN: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> window_count == $past(mode_b_q[6:5]))
        else $error("window count mismatch");
    AST_CRC: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(mode_c_q[0]) |=> crc_en)
        else $error("crc enable not followed");
    AST_DEFER: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_c_q[SDSC_B_DEFER] && mode_a_q[SDSC_B_TRIGGERED] && st_q == SDSC_IDLE)
        |=> st_q == SDSC_IDLE)
        else $error("event not deferred");

endmodule // sdsc_top

/* sim/testbench.sv */
// testbench: register, lane and sequencer checks of sdsc_top.
// assumes: sdsc_pkg compiled first; one 125 MHz clock, no partner model.
`timescale 1ns/100ps
module testbench;
    import sdsc_pkg::*;
    // ==========================================
    // signals and design
    logic clk, rst_n, reg_wr, reg_rd, trigger, eit1, eit2, eit3;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, dac_offset;
    logic [29:0] adc_data, lane_data;
    logic [9:0] train_word;
    logic seq_tick, pixel_reset, row_select, rov, row_skip, crc_en, fpn_cal, ndr_invalid, slope_reset;
    logic [1:0] window_count;
    logic [2:0] ndr_steps, seq_state;
    int failures, compares, cycles, n, k, p, m;
    logic [6:0] ra [16] = '{7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1e,
        7'h1f, 7'h20, 7'h21, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3a};
    logic [7:0] rv [16] = '{8'h20, 8'hc0, 8'hc0, 8'h2a, 8'h00, 8'h80, 8'h80, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h10, 8'h09};
    logic [6:0] lctl [3] = '{SDSC_A_L0_CTL, SDSC_A_L1_CTL, SDSC_A_L12_CTL};

    sdsc_top dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adc_data(adc_data), .trigger(trigger), .external_integration_timing_1(eit1),
        .external_integration_timing_2(eit2), .external_integration_timing_3(eit3),
        .lane_data(lane_data), .train_word(train_word), .dac_offset(dac_offset),
        .seq_tick(seq_tick), .pixel_reset(pixel_reset), .row_select(row_select),
        .row_overhead_interval(rov), .row_skip(row_skip), .window_count(window_count),
        .crc_en(crc_en), .fpn_cal(fpn_cal), .ndr_steps(ndr_steps),
        .ndr_invalid(ndr_invalid), .slope_reset(slope_reset), .seq_state(seq_state));

    // ==========================================
    // clock and hang guard
    initial
    begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    // ==========================================
    // tasks
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [29:0] got, input logic [29:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // access takes two cycles so strobes never toggle twice in one step
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr = 0;
        @(posedge clk) #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd = 0;
        check(reg_rdata, exp);
        @(posedge clk) #1;
    endtask

    // bounded wait on selected sequencer state bits
    task automatic wait_st(input logic [2:0] m, input logic [2:0] v);
        n = 0;
        while (((seq_state & m) !== v) && n < 400)
        begin
            @(posedge clk) #1;
            n++;
        end
        check(seq_state & m, v);
    endtask

    // skipped rows seen over nr row overhead intervals
    task automatic rows(input int nr, output int sk);
        sk = 0;
        repeat (nr)
        begin
            n = 0;
            while (rov === 1'b1 && n < 100)
            begin
                @(posedge clk) #1;
                n++;
            end
            while (rov !== 1'b1 && n < 200)
            begin
                @(posedge clk) #1;
                n++;
            end
            sk += row_skip;
        end
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        {reg_wr, reg_rd, trigger, eit1, eit2, eit3} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        adc_data = 30'h2aa5_5123;
        rst_n = 0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        @(posedge clk) #1;
        for (int i = 0; i < 16; i++) rd(ra[i], rv[i]);
        check(train_word, 10'h32a);
        check(dac_offset, 8'h80);
        wr(7'h00, 8'h5a);
        rd(7'h00, 8'h00);
        wr(SDSC_A_DAC, 8'h55);
        check(dac_offset, 8'h80);
        wr(SDSC_A_DPCFG_A, 8'h44);
        wr(SDSC_A_DPCFG_B, 8'h3c);
        check(dac_offset, 8'h55);
        check(train_word, 10'h13c);
        for (int i = 0; i < 3; i++)
        begin
            wr(lctl[i], 8'h34);
            wr(lctl[i] + 7'h01, 8'h5a);
            check(lane_data[i*10 +: 10], 10'h35a);
            wr(lctl[i], 8'h35);
            check(lane_data[i*10 +: 10], adc_data[i*10 +: 10]);
            wr(lctl[i], 8'h00);
            check(lane_data[i*10 +: 10], adc_data[i*10 +: 10]);
        end
        wr(SDSC_A_DPCFG_A, 8'h48);
        k = 0;
        repeat (40) @(posedge clk) #1 k += (lane_data[9:0] !== adc_data[9:0]);
        check(k != 0, 1);
        for (int w = 0; w < 4; w++)
        begin
            wr(SDSC_A_SEQ_B, {1'b0, w[1:0], 5'h11});
            check(window_count, w[1:0]);
        end
        wr(SDSC_A_SEQ_C, 8'h15);
        check({crc_en, fpn_cal, ndr_steps, ndr_invalid}, 6'b110100);
        wr(SDSC_A_SEQ_C, 8'h00);
        check({crc_en, fpn_cal, ndr_invalid}, 3'b001);
        // tick spacing: nine quiet cycles then the next pulse
        n = 0;
        while (seq_tick !== 1'b1 && n < 20)
        begin
            @(posedge clk) #1;
            n++;
        end
        k = 0;
        repeat (9) @(posedge clk) #1 k += seq_tick;
        check(k, 0);
        @(posedge clk) #1;
        check(seq_tick, 1'b1);
        wr(SDSC_A_SEQ_D, 8'h01);
        wr(SDSC_A_SEQ_C, 8'h49);
        wr(SDSC_A_SEQ_A, 8'h82);
        repeat (30) @(posedge clk) #1;
        check(seq_state, 3'b000);
        wr(SDSC_A_SEQ_A, 8'h83);
        wait_st(3'b001, 3'b001);
        wait_st(3'b010, 3'b010);
        @(posedge clk) #1;
        check(row_select, 1'b1);
        wr(SDSC_A_SEQ_A, 8'h06);
        wait_st(3'b111, 3'b000);
        wr(SDSC_A_SEQ_A, 8'h07);
        repeat (40) @(posedge clk) #1;
        check(seq_state, 3'b000);
        trigger = 1;
        @(posedge clk) #1;
        trigger = 0;
        wait_st(3'b001, 3'b001);
        // subsampling off, then mono and color skip counts
        rows(5, k);
        check(k, 0);
        check(rov, 1'b1);
        wr(SDSC_A_SEQ_A, 8'h0f);
        rows(5, k);
        check(k, 2);
        wr(SDSC_A_SEQ_A, 8'h1f);
        rows(8, k);
        check(k, 4);
        // fpn calibration samples the constant lane, correction cancels it
        wr(SDSC_A_SEQ_C, 8'h4d);
        rows(2, k);
        wr(SDSC_A_DPCFG_A, 8'h44);
        wr(SDSC_A_L0_CTL, 8'h02);
        check(lane_data[9:0], 10'h000);
        wr(SDSC_A_SEQ_A, 8'h06);
        wait_st(3'b111, 3'b000);
        // integration with dual and triple slope, clock granularity
        wr(SDSC_A_SEQ_A, 8'h63);
        k = 0;
        p = 0;
        m = 0;
        n = 0;
        while (seq_state[1] !== 1'b1 && n < 400)
        begin
            @(posedge clk) #1;
            k += slope_reset;
            p += pixel_reset;
            m += seq_state[0];
            n++;
        end
        check(m, 30);
        check(p != 0, 1);
        check(k != 0 && k < m, 1);
        wr(SDSC_A_SEQ_A, 8'h00);
        wait_st(3'b111, 3'b000);
        // slave mode: integration lasts while a timing pin is high
        eit2 = 1;
        wr(SDSC_A_SEQ_A, 8'h01);
        wait_st(3'b001, 3'b001);
        repeat (100) @(posedge clk) #1;
        check(seq_state, 3'b001);
        eit2 = 0;
        wait_st(3'b010, 3'b010);
        wr(SDSC_A_SEQ_A, 8'h00);
        wait_st(3'b111, 3'b000);
        // deferral holds a trigger taken in idle until it is cleared
        wr(SDSC_A_SEQ_C, 8'hc9);
        wr(SDSC_A_SEQ_A, 8'h07);
        trigger = 1;
        @(posedge clk) #1;
        trigger = 0;
        repeat (60) @(posedge clk) #1;
        check(seq_state, 3'b000);
        wr(SDSC_A_SEQ_C, 8'h49);
        wait_st(3'b001, 3'b001);
        end_sim();
    end
endmodule // testbench
